// ==== rtl/rtc_calendar_alarm_core.v ====
// Calendar counters, alarms, control registers and pin routing of the RTC core
`timescale 1ns/1ns
`include "rtc_defs.vh"

// Contract
// [R1] All time fields are kept in BCD
// [R2] Weekday advances at midnight, 7 wraps to 1
// [R3] Century bit toggles on year 99 to 00
// [R4] Hours bit 6 selects 12 or 24 hour
// [R5] Hours bit 5 is PM or tens bit
// [R6] Reset loads 00:00:00 00/01/01, weekday 01
// [R7] Alarm bit 7 masks; unmasked fields must match
// [R8] First alarm masks choose its repeat rate
// [R9] Second alarm masks choose its repeat rate
// [R10] Day/date bit 6 picks weekday or date compare
// [R11] Match sets flag regardless of enable
// [R12] Pin active only with flag and enable
// [R13] Control bit 7 stops oscillator, resets 0
// [R14] Control bit 5 enables glitch filter, resets 0
// [R15] Rate bits reset to 1, 32.768 kHz
// [R16] Slow output conditioned by valid reference only
// [R17] 1 Hz output jitter under 2 ms
// [R18] Steer 0: square on pin B
// [R19] Steer 1, ext 0: alarm1 A, alarm2 B
// [R20] Steer 1, ext 1: both alarms on B
// [R21] Steer and enables reset to 0
// [R22] Rate bits encode the four square frequencies
// [R23] Steer 0: pin A alarms or reference input
// [R24] Flag cleared by writing 0, 1 keeps it
// [R25] Interrupt pins are driven low when active
// [R26] Carries cascade with month lengths and leap years
// [R27] 12-hour count: 11 to 12 toggles PM
module rtc_calendar_alarm_core (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Register port from the serial interface
  input wire [3:0] reg_addr,
  input wire reg_wr_en,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Crystal oscillator level
  input wire osc_in,
  // Pin A: reference input or open-drain interrupt
  input wire refin_irq_a_pin_in,
  output wire refin_irq_a_pin_out,
  output reg refin_irq_a_pin_oe_n,
  // Pin B: open-drain square wave or interrupt
  output wire wave_irq_b_pin_out,
  output reg wave_irq_b_pin_oe_n
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [7:0] seconds_count, minutes_count, hours_count, weekday_count;
  reg [7:0] date_count, month_count, year_count;
  reg [7:0] alarm1_sec, alarm1_min, alarm1_hour, alarm1_daydate;
  reg [7:0] alarm2_min, alarm2_hour, alarm2_daydate, control, next_rdata;
  reg ext_ref_enable, alarm1_flag, alarm2_flag, tick_d;
  wire sec_tick, square_level, osc_stop_ctl, glitch_filter_on;
  wire interrupt_steer, alarm1_irq_en, alarm2_irq_en;
  wire [1:0] rate_sel;
  wire [7:0] hour_step, month_step, last_day;
  wire carry_sec, carry_min, carry_hour, carry_date, carry_month;
  wire alarm1_match, alarm2_match, irq1, irq2;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Two-digit BCD increment
  function [7:0] bcd_inc;
    input [7:0] v;
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction
  // Hour step in either format; bit 7 of the result is the day carry
  function [7:0] hour_inc;
    input [6:0] h;
    reg [7:0] t;
    begin
      t = bcd_inc({3'b000, h[4:0]});
      if (h[`RTC_BIT_HOUR_12H]) begin
        if (h[4:0] == 5'h12) begin
          hour_inc = {1'b0, h[6:5], 5'h01}; // [R27]
        end else if (h[4:0] == 5'h11) begin
          hour_inc = {h[5], h[6], ~h[5], 5'h12}; // [R5] [R27]
        end else begin
          hour_inc = {1'b0, h[6:5], t[4:0]};
        end
      end else if (h[5:0] == 6'h23) begin
        hour_inc = 8'h80;
      end else begin
        t = bcd_inc({2'b00, h[5:0]});
        hour_inc = {2'b00, t[5:0]}; // [R5]
      end
    end
  endfunction
  // Leap year test on a BCD year, every fourth year
  function is_leap;
    input [7:0] y;
    is_leap = y[4] ? ((y[3:0] == 4'h2) || (y[3:0] == 4'h6)) :
      ((y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8));
  endfunction
  // Last BCD date of a month
  function [7:0] month_end;
    input [4:0] m;
    input leap;
    begin
      case (m)
        5'h02: month_end = leap ? 8'h29 : 8'h28;
        5'h04, 5'h06, 5'h09, 5'h11: month_end = 8'h30;
        default: month_end = 8'h31;
      endcase
    end
  endfunction
  // Unmasked day/date compare against weekday or date
  function daydate_hit;
    input [7:0] a;
    input [7:0] wd;
    input [7:0] dt;
    daydate_hit = (a[5:0] == (a[`RTC_BIT_WEEKDAY_SEL] ? wd[5:0] : dt[5:0])); // [R10]
  endfunction

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  assign osc_stop_ctl = control[`RTC_BIT_OSC_STOP];
  assign glitch_filter_on = control[`RTC_BIT_GLITCH_ON];
  assign rate_sel = {control[`RTC_BIT_RATE_HI], control[`RTC_BIT_RATE_LO]};
  assign interrupt_steer = control[`RTC_BIT_STEER];
  assign alarm2_irq_en = control[`RTC_BIT_A2_IRQ_EN];
  assign alarm1_irq_en = control[`RTC_BIT_A1_IRQ_EN];

  // ----------------------------------------------------------------
  // Oscillator and 1 Hz source
  // ----------------------------------------------------------------
  rtc_osc_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .osc_in(osc_in),
    .ref_in(refin_irq_a_pin_in),
    .osc_stop_ctl(osc_stop_ctl),
    .glitch_filter_on(glitch_filter_on),
    .ext_ref_enable(ext_ref_enable),
    .rate_sel(rate_sel),
    .sec_tick(sec_tick),
    .square_level(square_level)
  );

  // ----------------------------------------------------------------
  // Carry chain
  // ----------------------------------------------------------------
  assign hour_step = hour_inc(hours_count[6:0]);
  assign last_day = month_end(month_count[4:0], is_leap(year_count));
  assign month_step = bcd_inc({3'b000, month_count[4:0]});
  assign carry_sec = sec_tick && (seconds_count == 8'h59);
  assign carry_min = carry_sec && (minutes_count == 8'h59);
  assign carry_hour = carry_min && hour_step[7]; // [R26]
  assign carry_date = carry_hour && (date_count == last_day); // [R26]
  assign carry_month = carry_date && (month_count[4:0] == 5'h12);

  // Time and calendar counters; a write to a field wins over its carry
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      seconds_count <= `RTC_RST_TIME; // [R6]
      minutes_count <= `RTC_RST_TIME;
      hours_count <= `RTC_RST_TIME;
      weekday_count <= `RTC_RST_DAY;
      date_count <= `RTC_RST_DATE;
      month_count <= `RTC_RST_MONTH;
      year_count <= `RTC_RST_TIME;
    end else begin
      if (reg_wr_en && reg_addr == `RTC_ADDR_SEC) begin
        seconds_count <= reg_wdata & `RTC_WMASK_SEC; // [R1]
      end else if (sec_tick) begin
        seconds_count <= carry_sec ? 8'h00 : bcd_inc(seconds_count); // [R1]
      end
      if (reg_wr_en && reg_addr == `RTC_ADDR_MIN) begin
        minutes_count <= reg_wdata & `RTC_WMASK_MIN;
      end else if (carry_sec) begin
        minutes_count <= carry_min ? 8'h00 : bcd_inc(minutes_count);
      end
      if (reg_wr_en && reg_addr == `RTC_ADDR_HOUR) begin
        hours_count <= reg_wdata & `RTC_WMASK_HOUR; // [R4]
      end else if (carry_min) begin
        hours_count <= {1'b0, hour_step[6:0]}; // [R4]
      end
      if (reg_wr_en && reg_addr == `RTC_ADDR_DAY) begin
        weekday_count <= reg_wdata & `RTC_WMASK_DAY;
      end else if (carry_hour) begin
        weekday_count <= (weekday_count == 8'h07) ? 8'h01 : bcd_inc(weekday_count); // [R2]
      end
      if (reg_wr_en && reg_addr == `RTC_ADDR_DATE) begin
        date_count <= reg_wdata & `RTC_WMASK_DATE;
      end else if (carry_hour) begin
        date_count <= carry_date ? 8'h01 : bcd_inc(date_count); // [R26]
      end
      if (reg_wr_en && reg_addr == `RTC_ADDR_MONTH) begin
        month_count <= reg_wdata & `RTC_WMASK_MONTH;
      end else if (carry_date) begin
        month_count[4:0] <= carry_month ? 5'h01 : month_step[4:0]; // [R1] [R26]
        if (carry_month && year_count == 8'h99) begin
          month_count[`RTC_BIT_CENTURY] <= ~month_count[`RTC_BIT_CENTURY]; // [R3]
        end
      end
      if (reg_wr_en && reg_addr == `RTC_ADDR_YEAR) begin
        year_count <= reg_wdata;
      end else if (carry_month) begin
        year_count <= (year_count == 8'h99) ? 8'h00 : bcd_inc(year_count); // [R3]
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarm and control registers
  // ----------------------------------------------------------------
  // Alarm values have no defined reset; zero keeps simulation clean
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      alarm1_sec <= 8'h00;
      alarm1_min <= 8'h00;
      alarm1_hour <= 8'h00;
      alarm1_daydate <= 8'h00;
      alarm2_min <= 8'h00;
      alarm2_hour <= 8'h00;
      alarm2_daydate <= 8'h00;
      control <= `RTC_RST_CONTROL; // [R13] [R14] [R15] [R21]
      ext_ref_enable <= 1'b0;
    end else if (reg_wr_en) begin
      case (reg_addr)
        `RTC_ADDR_A1_SEC: alarm1_sec <= reg_wdata;
        `RTC_ADDR_A1_MIN: alarm1_min <= reg_wdata;
        `RTC_ADDR_A1_HOUR: alarm1_hour <= reg_wdata;
        `RTC_ADDR_A1_DD: alarm1_daydate <= reg_wdata;
        `RTC_ADDR_A2_MIN: alarm2_min <= reg_wdata;
        `RTC_ADDR_A2_HOUR: alarm2_hour <= reg_wdata;
        `RTC_ADDR_A2_DD: alarm2_daydate <= reg_wdata;
        `RTC_ADDR_CONTROL: control <= reg_wdata & `RTC_WMASK_CONTROL;
        `RTC_ADDR_STATUS: ext_ref_enable <= reg_wdata[`RTC_BIT_EXT_REF];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Alarm compare, one cycle after the counters moved
  // ----------------------------------------------------------------
  assign alarm1_match = tick_d &&
    (alarm1_sec[7] || alarm1_sec[6:0] == seconds_count[6:0]) &&
    (alarm1_min[7] || alarm1_min[6:0] == minutes_count[6:0]) &&
    (alarm1_hour[7] || alarm1_hour[6:0] == hours_count[6:0]) &&
    (alarm1_daydate[7] || daydate_hit(alarm1_daydate, weekday_count, date_count)); // [R7] [R8]
  assign alarm2_match = tick_d && (seconds_count == 8'h00) &&
    (alarm2_min[7] || alarm2_min[6:0] == minutes_count[6:0]) &&
    (alarm2_hour[7] || alarm2_hour[6:0] == hours_count[6:0]) &&
    (alarm2_daydate[7] || daydate_hit(alarm2_daydate, weekday_count, date_count)); // [R7] [R9]

  // Flags: a match in the clearing cycle keeps the flag set
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_d <= 1'b0;
      alarm1_flag <= 1'b0;
      alarm2_flag <= 1'b0;
    end else begin
      tick_d <= sec_tick;
      if (reg_wr_en && reg_addr == `RTC_ADDR_STATUS) begin
        alarm1_flag <= (alarm1_flag & reg_wdata[`RTC_BIT_A1_FLAG]) | alarm1_match; // [R24]
        alarm2_flag <= (alarm2_flag & reg_wdata[`RTC_BIT_A2_FLAG]) | alarm2_match; // [R24]
      end else begin
        alarm1_flag <= alarm1_flag | alarm1_match; // [R11]
        alarm2_flag <= alarm2_flag | alarm2_match; // [R11]
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------
  assign irq1 = alarm1_flag && alarm1_irq_en; // [R12]
  assign irq2 = alarm2_flag && alarm2_irq_en; // [R12]
  assign refin_irq_a_pin_out = 1'b0; // [R25]
  assign wave_irq_b_pin_out = 1'b0;

  // Open-drain: enable low pulls the pin low, high releases it
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      refin_irq_a_pin_oe_n <= 1'b1;
      wave_irq_b_pin_oe_n <= 1'b1;
    end else if (!interrupt_steer) begin
      wave_irq_b_pin_oe_n <= square_level; // [R18]
      refin_irq_a_pin_oe_n <= ext_ref_enable | ~(irq1 | irq2); // [R23] [R25]
    end else if (!ext_ref_enable) begin
      refin_irq_a_pin_oe_n <= ~irq1; // [R19]
      wave_irq_b_pin_oe_n <= ~irq2; // [R19]
    end else begin
      refin_irq_a_pin_oe_n <= 1'b1;
      wave_irq_b_pin_oe_n <= ~(irq1 | irq2); // [R20]
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always @* begin
    case (reg_addr)
      `RTC_ADDR_SEC: next_rdata = seconds_count;
      `RTC_ADDR_MIN: next_rdata = minutes_count;
      `RTC_ADDR_HOUR: next_rdata = hours_count;
      `RTC_ADDR_DAY: next_rdata = weekday_count;
      `RTC_ADDR_DATE: next_rdata = date_count;
      `RTC_ADDR_MONTH: next_rdata = month_count;
      `RTC_ADDR_YEAR: next_rdata = year_count;
      `RTC_ADDR_A1_SEC: next_rdata = alarm1_sec;
      `RTC_ADDR_A1_MIN: next_rdata = alarm1_min;
      `RTC_ADDR_A1_HOUR: next_rdata = alarm1_hour;
      `RTC_ADDR_A1_DD: next_rdata = alarm1_daydate;
      `RTC_ADDR_A2_MIN: next_rdata = alarm2_min;
      `RTC_ADDR_A2_HOUR: next_rdata = alarm2_hour;
      `RTC_ADDR_A2_DD: next_rdata = alarm2_daydate;
      `RTC_ADDR_CONTROL: next_rdata = control;
      default: next_rdata = {5'h00, ext_ref_enable, alarm2_flag, alarm1_flag};
    endcase
  end

  // Registered read data follows the address one cycle later
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// ==== rtl/rtc_defs.vh ====
// Register offsets, field positions, reset values and timing counts of the RTC core
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RTC_ADDR_SEC 4'h0
`define RTC_ADDR_MIN 4'h1
`define RTC_ADDR_HOUR 4'h2
`define RTC_ADDR_DAY 4'h3
`define RTC_ADDR_DATE 4'h4
`define RTC_ADDR_MONTH 4'h5
`define RTC_ADDR_YEAR 4'h6
`define RTC_ADDR_A1_SEC 4'h7
`define RTC_ADDR_A1_MIN 4'h8
`define RTC_ADDR_A1_HOUR 4'h9
`define RTC_ADDR_A1_DD 4'ha
`define RTC_ADDR_A2_MIN 4'hb
`define RTC_ADDR_A2_HOUR 4'hc
`define RTC_ADDR_A2_DD 4'hd
`define RTC_ADDR_CONTROL 4'he
`define RTC_ADDR_STATUS 4'hf

// ----------------------------------------------------------------
// Writable bits per register; the rest read as zero
// ----------------------------------------------------------------
`define RTC_WMASK_SEC 8'h7f
`define RTC_WMASK_MIN 8'h7f
`define RTC_WMASK_HOUR 8'h7f
`define RTC_WMASK_DAY 8'h07
`define RTC_WMASK_DATE 8'h3f
`define RTC_WMASK_MONTH 8'h9f
`define RTC_WMASK_CONTROL 8'hbf

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RTC_BIT_ALARM_MASK 7
`define RTC_BIT_WEEKDAY_SEL 6
`define RTC_BIT_HOUR_12H 6
`define RTC_BIT_HOUR_PM 5
`define RTC_BIT_CENTURY 7
`define RTC_BIT_OSC_STOP 7
`define RTC_BIT_GLITCH_ON 5
`define RTC_BIT_RATE_HI 4
`define RTC_BIT_RATE_LO 3
`define RTC_BIT_STEER 2
`define RTC_BIT_A2_IRQ_EN 1
`define RTC_BIT_A1_IRQ_EN 0
`define RTC_BIT_EXT_REF 2
`define RTC_BIT_A2_FLAG 1
`define RTC_BIT_A1_FLAG 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RTC_RST_TIME 8'h00
`define RTC_RST_DAY 8'h01
`define RTC_RST_DATE 8'h01
`define RTC_RST_MONTH 8'h01
`define RTC_RST_CONTROL 8'h18

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RTC_CLK_PERIOD_NS 4
`define RTC_GLITCH_NS 5000
`define RTC_GLITCH_CYC ((`RTC_GLITCH_NS + `RTC_CLK_PERIOD_NS - 1) / `RTC_CLK_PERIOD_NS)
`define RTC_OSC_HZ 32768
`define RTC_REF_TOL_PERMIL 8
`define RTC_REF_TOL_CNT ((`RTC_OSC_HZ * `RTC_REF_TOL_PERMIL) / 1000)
`define RTC_JITTER_MS 2
`define RTC_SKEW_CNT ((`RTC_OSC_HZ * `RTC_JITTER_MS) / 1000)

`endif

// ==== rtl/rtc_osc_prescaler.v ====
// Oscillator conditioning, 1 Hz prescaler, reference lock and square-wave select
`timescale 1ns/1ns
`include "rtc_defs.vh"

module rtc_osc_prescaler (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Oscillator and reference pins
  input wire osc_in,
  input wire ref_in,
  // Controls
  input wire osc_stop_ctl,
  input wire glitch_filter_on,
  input wire ext_ref_enable,
  input wire [1:0] rate_sel,
  // Results
  output reg sec_tick,
  output reg square_level
);

  reg [1:0] osc_sync;
  reg [1:0] ref_sync;
  reg osc_filt;
  reg osc_prev;
  reg ref_prev;
  reg [10:0] glitch_cnt;
  reg [14:0] pre;
  reg [15:0] ref_period;
  reg [14:0] lock_phase;
  reg locked;
  wire osc_rise;
  wire ref_rise;
  wire ref_valid;
  wire [14:0] skew;
  wire skew_big;
  reg next_square;

  // Limits kept as integers; each compare takes only the bits it needs
  localparam integer GLITCH_LAST = `RTC_GLITCH_CYC - 1;
  localparam integer REF_LOW = `RTC_OSC_HZ - `RTC_REF_TOL_CNT;
  localparam integer REF_HIGH = `RTC_OSC_HZ + `RTC_REF_TOL_CNT;
  localparam integer SKEW_LOW = `RTC_SKEW_CNT;
  localparam integer SKEW_HIGH = `RTC_OSC_HZ - `RTC_SKEW_CNT;

  // ----------------------------------------------------------------
  // Pin synchronisers and glitch filter
  // ----------------------------------------------------------------
  // Filter lets a new level through only after it held steady long enough
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      osc_sync <= 2'b00;
      ref_sync <= 2'b00;
      osc_filt <= 1'b0;
      glitch_cnt <= 11'h000;
    end else begin
      osc_sync <= {osc_sync[0], osc_in};
      ref_sync <= {ref_sync[0], ref_in};
      if (!glitch_filter_on || osc_sync[1] == osc_filt) begin
        glitch_cnt <= 11'h000;
        osc_filt <= osc_sync[1];
      end else if (glitch_cnt == GLITCH_LAST[10:0]) begin
        glitch_cnt <= 11'h000; // [R14]
        osc_filt <= osc_sync[1];
      end else begin
        glitch_cnt <= glitch_cnt + 11'h001;
      end
    end
  end

  // A stopped oscillator produces no edges at all
  assign osc_rise = osc_filt && !osc_prev && !osc_stop_ctl; // [R13]
  assign ref_rise = ref_sync[1] && !ref_prev && ext_ref_enable;
  assign ref_valid = (ref_period >= REF_LOW[15:0]) &&
                     (ref_period <= REF_HIGH[15:0]); // [R16]
  assign skew = pre - lock_phase;
  assign skew_big = (skew >= SKEW_LOW[14:0]) && (skew <= SKEW_HIGH[14:0]);

  // ----------------------------------------------------------------
  // Prescaler with reference correction
  // ----------------------------------------------------------------
  // A correction may drop or repeat one tick; skew is held under the jitter bound
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      osc_prev <= 1'b0;
      ref_prev <= 1'b0;
      pre <= 15'h0000;
      ref_period <= 16'h0000;
      lock_phase <= 15'h0000;
      locked <= 1'b0;
      sec_tick <= 1'b0;
    end else begin
      osc_prev <= osc_filt;
      ref_prev <= ref_sync[1];
      sec_tick <= osc_rise && (pre == 15'h7fff);
      if (ref_rise) begin
        ref_period <= 16'h0000;
        if (!ref_valid) begin
          locked <= 1'b0;
        end else if (!locked) begin
          locked <= 1'b1;
          lock_phase <= pre;
        end
      end else if (osc_rise && ref_period != 16'hffff) begin
        ref_period <= ref_period + 16'h0001;
      end
      if (!ext_ref_enable) begin
        locked <= 1'b0;
      end
      if (ref_rise && ref_valid && locked && skew_big) begin
        pre <= lock_phase; // [R16] [R17]
      end else if (osc_rise) begin
        pre <= pre + 15'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Square-wave rate select
  // ----------------------------------------------------------------
  always @* begin
    case (rate_sel)
      2'b00: next_square = pre[14]; // [R22]
      2'b01: next_square = pre[2];
      2'b10: next_square = pre[1];
      default: next_square = osc_filt; // [R15]
    endcase
  end

  // Only the 32.768 kHz rate bypasses the corrected divider chain
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      square_level <= 1'b0;
    end else if (!osc_stop_ctl) begin
      square_level <= next_square;
    end
  end

endmodule

// ==== verif/rtc_core_checker.sv ====
// Port-level checks of the RTC core
`timescale 1ns/1ns
module rtc_core_checker (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Register port
  input wire [3:0] reg_addr,
  input wire reg_wr_en,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Pins
  input wire osc_in,
  input wire refin_irq_a_pin_out,
  input wire refin_irq_a_pin_oe_n,
  input wire wave_irq_b_pin_out,
  input wire wave_irq_b_pin_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  reg [7:0] ctrl;
  reg ext;
  reg osc_q;
  reg [2:0] quiet;
  // Snooped control and reference enable; quiet counts settled cycles
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= 8'h18;
      ext <= 1'b0;
      osc_q <= 1'b0;
      quiet <= 3'h0;
    end else begin
      osc_q <= osc_in;
      if (reg_wr_en && reg_addr == 4'he) ctrl <= reg_wdata & 8'hbf;
      if (reg_wr_en && reg_addr == 4'hf) ext <= reg_wdata[2];
      if (osc_in != osc_q || reg_wr_en) quiet <= 3'h0;
      else if (quiet != 3'h7) quiet <= quiet + 3'h1;
    end
  end
  a_pin_a_low: assert property (refin_irq_a_pin_out == 1'b0) else $error("pin A drive not 0");
  a_pin_b_low: assert property (wave_irq_b_pin_out == 1'b0) else $error("pin B drive not 0");
  a_ctrl_readback: assert property ((reg_wr_en && reg_addr == 4'he) ##1
    (reg_addr == 4'he && !reg_wr_en) |=> reg_rdata == ($past(reg_wdata, 2) & 8'hbf))
    else $error("control readback wrong");
  a_sec_readback: assert property ((reg_wr_en && reg_addr == 4'h0) ##1
    (reg_addr == 4'h0 && !reg_wr_en) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h7f))
    else $error("seconds readback wrong");
  a_month_zeros: assert property (reg_addr == 4'h5 |=> reg_rdata[6:5] == 2'b00)
    else $error("month zero bits set");
  a_status_zeros: assert property (reg_addr == 4'hf |=> reg_rdata[7:3] == 5'h00)
    else $error("status upper bits set");
  a_irq_gated: assert property ((ctrl[2] && ctrl[1:0] == 2'b00) [*3] |->
    refin_irq_a_pin_oe_n && wave_irq_b_pin_oe_n) else $error("pin active without enable");
  a_ref_released: assert property (ext [*3] |-> refin_irq_a_pin_oe_n)
    else $error("pin A driven while reference input");
  a_square_follow: assert property (quiet == 3'h6 && ctrl == 8'h18 |->
    wave_irq_b_pin_oe_n == osc_in) else $error("pin B not following oscillator");
endmodule
bind rtc_calendar_alarm_core rtc_core_checker rtc_core_checker_i (.ref_clk(ref_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .osc_in(osc_in), .refin_irq_a_pin_out(refin_irq_a_pin_out),
  .refin_irq_a_pin_oe_n(refin_irq_a_pin_oe_n), .wave_irq_b_pin_out(wave_irq_b_pin_out),
  .wave_irq_b_pin_oe_n(wave_irq_b_pin_oe_n));

// ==== verif/rtc_host_model.sv ====
// Host side of the register port
`timescale 1ns/1ns
module rtc_host_model (
  // Clock
  input wire ref_clk,
  // Register port
  output reg [3:0] reg_addr,
  output reg reg_wr_en,
  output reg [7:0] reg_wdata,
  input wire [7:0] reg_rdata
);
  initial begin
    reg_addr = 4'h0;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
  end
  // One byte write; stale data is inverted so nothing leans on it
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wr_en <= 1'b1;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr_en <= 1'b0;
      reg_wdata <= ~d;
    end
  endtask
  // Read: address taken at one edge, data settled just after the next
  task rd(input [3:0] a, output [7:0] d);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      @(posedge ref_clk);
      #1 d = reg_rdata;
    end
  endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench of the RTC core
`timescale 1ns/1ns
module tb;
  reg ref_clk = 1'b0;
  reg nrst = 1'b0;
  reg osc_in = 1'b0;
  wire [3:0] reg_addr;
  wire reg_wr_en;
  wire [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire a_oe_n;
  wire b_oe_n;
  integer error_cnt = 0;
  integer samples_checked = 0;
  integer i;
  reg [3:0] a;
  reg [7:0] d;
  reg [7:0] q;
  // Bytes for indices 0..7: 23:59:59, weekday 7, 31/12/99, first alarm at second 00
  reg [63:0] year_end = 64'h0099123107235959;
  always #2 ref_clk = ~ref_clk;
  rtc_host_model host_i (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // Pin A is pulled up, so its level is its own enable
  rtc_calendar_alarm_core rtc_calendar_alarm_core_i (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .osc_in(osc_in), .refin_irq_a_pin_in(a_oe_n), .refin_irq_a_pin_out(),
    .refin_irq_a_pin_oe_n(a_oe_n), .wave_irq_b_pin_out(), .wave_irq_b_pin_oe_n(b_oe_n));
  // Writable bits per index; flags refuse ones, so only bit 2 of status
  function [7:0] wmask(input [3:0] x);
    case (x)
      4'h0, 4'h1, 4'h2: wmask = 8'h7f;
      4'h3: wmask = 8'h07;
      4'h4: wmask = 8'h3f;
      4'h5: wmask = 8'h9f;
      4'he: wmask = 8'hbf;
      4'hf: wmask = 8'h04;
      default: wmask = 8'hff;
    endcase
  endfunction
  // Power-on value per index
  function [7:0] rstv(input [3:0] x);
    rstv = (x == 4'he) ? 8'h18 : (x >= 4'h3 && x <= 4'h5) ? 8'h01 : 8'h00;
  endfunction
  task cmp(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    i = $urandom(32'ha66b);
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    for (i = 0; i < 16; i = i + 1) begin
      host_i.rd(i[3:0], q);
      cmp(q, rstv(i[3:0]));
    end
    host_i.wr(4'he, 8'hff);
    host_i.rd(4'he, q);
    cmp(q, 8'hbf);
    // Random bytes to random places, read straight back
    for (i = 0; i < 40; i = i + 1) begin
      a = 4'($urandom);
      d = 8'($urandom);
      host_i.wr(a, d);
      host_i.rd(a, q);
      cmp(q, d & wmask(a));
    end
    // Pin B follows the oscillator at the top rate, then freezes once stopped
    host_i.wr(4'hf, 8'h00);
    for (i = 0; i < 12; i = i + 1) begin
      if (i == 0) host_i.wr(4'he, 8'h18);
      if (i == 6) host_i.wr(4'he, 8'h98);
      @(posedge ref_clk);
      osc_in <= ~osc_in;
      repeat (8) @(posedge ref_clk);
      #1 cmp({7'h0, b_oe_n}, {7'h0, (i < 6) ? osc_in : d[0]});
      if (i == 5) d[0] = osc_in;
    end
    // Steered alarms enabled but no flags: both pins stay released
    host_i.wr(4'he, 8'h07);
    repeat (4) @(posedge ref_clk);
    #1 cmp({6'h0, a_oe_n, b_oe_n}, 8'h03);
    // Year end plus alarms masked except first alarm second 00; one tick must roll every field
    for (i = 0; i < 14; i = i + 1) begin
      host_i.wr(i[3:0], (i > 7) ? 8'h80 : year_end[8*i+:8]);
    end
    // Toggling every clock: 32768 rises always hold exactly one tick
    repeat (65536) @(posedge ref_clk) osc_in <= ~osc_in;
    repeat (12) @(posedge ref_clk);
    for (i = 0; i < 7; i = i + 1) begin
      host_i.rd(i[3:0], q);
      cmp(q, (i == 5) ? 8'h81 : rstv(i[3:0]));
    end
    host_i.rd(4'hf, q);
    cmp(q, 8'h03);
    cmp({6'h0, a_oe_n, b_oe_n}, 8'h00);
    // Ones keep the flags, zeros clear them and free the pins
    host_i.wr(4'hf, 8'h03);
    host_i.rd(4'hf, q);
    cmp(q, 8'h03);
    host_i.wr(4'hf, 8'h00);
    host_i.rd(4'hf, q);
    cmp(q, 8'h00);
    cmp({6'h0, a_oe_n, b_oe_n}, 8'h03);
    wrap_up;
  end
  // Whole run needs about 66000 cycles, almost all of it the one-second tick
  initial begin
    repeat (90000) @(posedge ref_clk);
    error_cnt = error_cnt + 1;
    wrap_up;
  end
endmodule
